// ---- rtl/rimf_pkg.sv ----
package rimf_pkg;
  localparam int          BYTE_W          = 8;
  localparam int          BUF_DEPTH       = 32;
  localparam logic [7:0]  SFR_DATA_ADDR   = 8'hD9;
  localparam logic [15:0] EXT_IRQM1_ADDR  = 16'h61A4;
  localparam logic [15:0] EXT_ERRM_ADDR   = 16'h61A5;
  localparam logic [15:0] EXT_RXCNT_ADDR  = 16'h61EA;
  localparam logic [15:0] EXT_TXCNT_ADDR  = 16'h61EB;
  localparam int          IRQM1_W         = 6;
  localparam int          ERRM_W          = 7;
  localparam logic [5:0]  IRQM1_RESET     = 6'h00;
  localparam logic [6:0]  ERRM_RESET      = 7'h00;
  localparam logic [7:0]  DATA_RESET      = 8'h00;
  localparam logic [7:0]  UNMAPPED_VALUE  = 8'h00;
  // Position of this block's line among the DMA controller triggers
  localparam int          DMA_TRIG_RADIO  = 19;
endpackage : rimf_pkg

// ---- rtl/rimf_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module rimf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // Fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // Drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // Control and level
  input  wire logic                     flush,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("rimf_fifo: DEPTH must be a power of two of at least 2");
  end

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign level     = count;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    // Flush wins over a push or pop in the same cycle
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end else begin
      if (push) begin
        next_wr_ptr = wr_ptr + AW'(1);
      end
      if (pop) begin
        next_rd_ptr = rd_ptr + AW'(1);
      end
      next_count = count + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (push && !flush && wr_ptr == AW'(i)) begin
        mem[i] <= in_data;
      end
    end
  end
endmodule : rimf_fifo

// Function
// - Mask bit 5 enables sequencer wait-resumed interrupt; resets 0.
// - Mask bit 4 enables sequencer stopped interrupt; resets 0.
// - Mask bit 3 enables sequencer manual interrupt; resets 0.
// - Mask bit 2 enables radio went idle interrupt; resets 0.
// - Mask bit 1 enables frame sent interrupt; resets 0.
// - Mask bit 0 enables acknowledgment frame sent interrupt; resets 0.
// - Error mask bit 6 enables strobe timing error; bit 7 reads zero.
// - Strobe error on disabling disabled radio or ack strobes outside reception.
// - Error mask bits 5..2 enable tx/rx buffer underflow and overflow.
// - Error mask bit 1 enables frame reception aborted interrupt.
// - Error mask bit 0 enables synthesizer lock failure interrupt.
// - Each data port write appends the byte to the transmit buffer unless it is full or a transmit flush strobe comes in the same cycle.
// - Each data port read of a nonempty receive buffer returns its next byte.
// - Receive and transmit count registers report bytes held.
// - Flush strobes empty the receive or transmit buffer.
// - Exactly one DMA trigger line, number 19, belongs to the radio.
// - DMA trigger pulses when receive buffer goes empty to nonempty.
// - DMA trigger pulses on data port read leaving bytes behind.
module rimf_top
  import rimf_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Special-function register access
  input  wire logic [7:0]            sfr_addr,
  input  wire logic                  sfr_wr,
  input  wire logic                  sfr_rd,
  input  wire logic [7:0]            sfr_wdata,
  output logic [7:0]                 sfr_rdata,
  // Extended register access
  input  wire logic [15:0]           ext_addr,
  input  wire logic                  ext_wr,
  input  wire logic                  ext_rd,
  input  wire logic [7:0]            ext_wdata,
  output logic [7:0]                 ext_rdata,
  // Radio receive byte stream
  input  wire logic                  rx_in_valid,
  output logic                       rx_in_ready,
  input  wire logic [7:0]            rx_in_data,
  // Radio transmit byte stream
  output logic                       tx_out_valid,
  input  wire logic                  tx_out_ready,
  output logic [7:0]                 tx_out_data,
  // Command strobes and radio state
  input  wire logic                  flush_rx_strobe,
  input  wire logic                  flush_tx_strobe,
  input  wire logic                  ack_strobe,
  input  wire logic                  ack_pending_strobe,
  input  wire logic                  no_ack_strobe,
  input  wire logic                  radio_off_strobe,
  input  wire logic                  radio_enabled,
  input  wire logic                  rx_active,
  // Pending flags from the flag registers
  input  wire logic [IRQM1_W-1:0]    irq1_pending,
  input  wire logic [ERRM_W-1:0]     err_pending,
  // Error events towards the flag registers
  output logic                       strobe_timing_error,
  output logic                       tx_buf_underflow,
  output logic                       tx_buf_overflow,
  output logic                       rx_buf_underflow,
  output logic                       rx_buf_overflow,
  // Interrupt requests and DMA trigger
  output logic                       radio_irq,
  output logic                       radio_err_irq,
  output logic                       dma_trigger
);
  import rimf_pkg::*;

  localparam int CW = $clog2(DEPTH) + 1;

  logic [IRQM1_W-1:0] irq_mask;
  logic [ERRM_W-1:0]  err_mask;
  logic [7:0]         data_q;
  logic [7:0]         xrd_q;
  logic [IRQM1_W-1:0] next_irq_mask;
  logic [ERRM_W-1:0]  next_err_mask;
  logic [7:0]         next_data_q;
  logic [7:0]         next_xrd_q;
  logic [4:0]         evt;
  logic [4:0]         next_evt;
  logic               rx_empty_q;
  logic               next_dma;
  logic               next_irq;
  logic               next_err_irq;
  logic [CW-1:0]      rx_count;
  logic [CW-1:0]      tx_count;
  logic               tx_in_ready;
  logic               rx_out_valid;
  logic [7:0]         rx_out_data;
  logic               data_wr;
  logic               data_rd;
  logic               rx_pop;

  if (CW > 8) begin : g_bad
    $error("rimf_top: buffer count must fit in one byte");
  end

  assign data_wr = sfr_wr && (sfr_addr == SFR_DATA_ADDR);
  assign data_rd = sfr_rd && (sfr_addr == SFR_DATA_ADDR);
  assign rx_pop  = data_rd && rx_out_valid;

  rimf_fifo #(.WIDTH(BYTE_W), .DEPTH(DEPTH)) u_tx_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (data_wr),
    .in_ready  (tx_in_ready),
    .in_data   (sfr_wdata),
    .out_valid (tx_out_valid),
    .out_ready (tx_out_ready),
    .out_data  (tx_out_data),
    .flush     (flush_tx_strobe),
    .level     (tx_count)
  );

  rimf_fifo #(.WIDTH(BYTE_W), .DEPTH(DEPTH)) u_rx_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .in_data   (rx_in_data),
    .out_valid (rx_out_valid),
    .out_ready (data_rd),
    .out_data  (rx_out_data),
    .flush     (flush_rx_strobe),
    .level     (rx_count)
  );

  always_comb begin
    next_irq_mask = irq_mask;
    next_err_mask = err_mask;
    next_data_q   = data_q;
    next_xrd_q    = xrd_q;
    if (ext_wr && ext_addr == EXT_IRQM1_ADDR) begin
      next_irq_mask = ext_wdata[IRQM1_W-1:0];
    end
    if (ext_wr && ext_addr == EXT_ERRM_ADDR) begin
      next_err_mask = ext_wdata[ERRM_W-1:0];
    end
    if (rx_pop) begin
      next_data_q = rx_out_data;
    end
    if (ext_rd) begin
      unique case (ext_addr)
        EXT_IRQM1_ADDR: next_xrd_q = {2'h0, irq_mask};
        EXT_ERRM_ADDR:  next_xrd_q = {1'h0, err_mask};
        EXT_RXCNT_ADDR: next_xrd_q = 8'(rx_count);
        EXT_TXCNT_ADDR: next_xrd_q = 8'(tx_count);
        default:         next_xrd_q = UNMAPPED_VALUE;
      endcase
    end
  end

  always_comb begin
    // Event order: strobe, tx under, tx over, rx under, rx over
    next_evt[4] = (radio_off_strobe && !radio_enabled)
                  || ((ack_strobe || ack_pending_strobe || no_ack_strobe) && !rx_active);
    next_evt[3] = tx_out_ready && !tx_out_valid;
    next_evt[2] = data_wr && !tx_in_ready && !flush_tx_strobe;
    next_evt[1] = data_rd && !rx_out_valid;
    next_evt[0] = rx_in_valid && !rx_in_ready && !flush_rx_strobe;
    // A pop refilled by a same-cycle push still leaves a byte behind
    next_dma     = (rx_empty_q && rx_count != '0)
                   || (rx_pop && !flush_rx_strobe
                       && (rx_count > CW'(1) || (rx_in_valid && rx_in_ready)));
    next_irq     = |(irq1_pending & irq_mask);
    next_err_irq = |(err_pending & err_mask);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask      <= IRQM1_RESET;
      err_mask      <= ERRM_RESET;
      data_q        <= DATA_RESET;
      xrd_q         <= UNMAPPED_VALUE;
      evt           <= '0;
      rx_empty_q    <= 1'b1;
      dma_trigger   <= 1'b0;
      radio_irq     <= 1'b0;
      radio_err_irq <= 1'b0;
    end else begin
      irq_mask      <= next_irq_mask;
      err_mask      <= next_err_mask;
      data_q        <= next_data_q;
      xrd_q         <= next_xrd_q;
      evt           <= next_evt;
      rx_empty_q    <= (rx_count == '0);
      dma_trigger   <= next_dma;
      radio_irq     <= next_irq;
      radio_err_irq <= next_err_irq;
    end
  end

  assign sfr_rdata           = data_q;
  assign ext_rdata           = xrd_q;
  assign strobe_timing_error = evt[4];
  assign tx_buf_underflow    = evt[3];
  assign tx_buf_overflow     = evt[2];
  assign rx_buf_underflow    = evt[1];
  assign rx_buf_overflow     = evt[0];

  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 radio_irq == $past(|(irq1_pending & irq_mask)))
    else $error("radio_irq does not follow flags and mask");
  a_irq_mask_write: assert property (@(posedge clk) disable iff (!rst_b)
    ext_wr && ext_addr == EXT_IRQM1_ADDR ##1 !ext_wr [*2]
    ##1 ext_rd && ext_addr == EXT_IRQM1_ADDR
    |=> ext_rdata == {2'h0, $past(ext_wdata[IRQM1_W-1:0], 4)})
    else $error("interrupt mask readback wrong");
  a_err_mask_gate: assert property (@(posedge clk) disable iff (!rst_b)
    ext_wr && ext_addr == EXT_ERRM_ADDR && ext_wdata == 8'h00
    ##1 !(ext_wr && ext_addr == EXT_ERRM_ADDR) |=> !radio_err_irq)
    else $error("error interrupt with all error masks cleared");
  a_strobe_err: assert property (@(posedge clk) disable iff (!rst_b)
    (no_ack_strobe && !rx_active) || (radio_off_strobe && !radio_enabled)
    |=> strobe_timing_error)
    else $error("strobe timing error missing");
  a_tx_append: assert property (@(posedge clk) disable iff (!rst_b)
    data_wr && tx_in_ready && !flush_tx_strobe && !(tx_out_valid && tx_out_ready)
    |=> tx_count == $past(tx_count) + CW'(1))
    else $error("data port write not appended");
  a_rx_read: assert property (@(posedge clk) disable iff (!rst_b)
    rx_pop |=> sfr_rdata == $past(rx_out_data))
    else $error("data port read returned wrong byte");
  a_flush_empty: assert property (@(posedge clk) disable iff (!rst_b)
    flush_rx_strobe ##1 !rx_in_valid |-> rx_count == '0 && !rx_out_valid)
    else $error("receive flush left bytes");
  a_dma_first: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rx_count) == '0 && rx_count != '0 |=> dma_trigger)
    else $error("no DMA trigger on first receive byte");
  a_dma_more: assert property (@(posedge clk) disable iff (!rst_b)
    !dma_trigger ##1 dma_trigger |-> $past(rx_pop) || $past(rx_count, 2) == '0)
    else $error("DMA trigger without cause");
endmodule : rimf_top

`default_nettype wire

// ---- bench/rimf_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module rimf_cpu_model (
  // Clock
  input  wire logic        clk,
  // Special-function register side
  output logic [7:0]       sfr_addr,
  output logic             sfr_wr,
  output logic             sfr_rd,
  output logic [7:0]       sfr_wdata,
  input  wire logic [7:0]  sfr_rdata,
  // Extended register side
  output logic [15:0]      ext_addr,
  output logic             ext_wr,
  output logic             ext_rd,
  output logic [7:0]       ext_wdata,
  input  wire logic [7:0]  ext_rdata
);
  initial begin
    {sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = '0;
    {ext_addr, ext_wr, ext_rd, ext_wdata} = '0;
  end

  // One access; read data taken once it has settled
  task automatic acc(input logic x, input logic wr, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    if (x) begin
      ext_addr  <= a;
      ext_wr    <= wr;
      ext_rd    <= !wr;
      ext_wdata <= d;
    end else begin
      sfr_addr  <= a[7:0];
      sfr_wr    <= wr;
      sfr_rd    <= !wr;
      sfr_wdata <= d;
    end
    @(posedge clk);
    {sfr_wr, sfr_rd, ext_wr, ext_rd} <= 4'h0;
    // Released lines do not keep their last value
    sfr_addr  <= ~sfr_addr;
    sfr_wdata <= ~sfr_wdata;
    ext_addr  <= ~ext_addr;
    ext_wdata <= ~ext_wdata;
    @(posedge clk);
    #1;
    q = x ? ext_rdata : sfr_rdata;
  endtask : acc
endmodule : rimf_cpu_model

`default_nettype wire

// ---- bench/radio_irq_mask_fifo_port_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module radio_irq_mask_fifo_port_test;
  import rimf_pkg::*;
  logic clk, rst_b, sfr_wr, sfr_rd, ext_wr, ext_rd, rx_in_valid, rx_in_ready;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, ext_wdata, ext_rdata, rx_in_data, tx_out_data;
  logic [15:0] ext_addr;
  logic tx_out_valid, tx_out_ready, flush_rx_strobe, flush_tx_strobe, radio_enabled, rx_active;
  logic ack_strobe, ack_pending_strobe, no_ack_strobe, radio_off_strobe;
  logic [3:0] strb;
  logic [IRQM1_W-1:0] irq1_pending;
  logic [ERRM_W-1:0] err_pending;
  logic strobe_timing_error, tx_buf_underflow, tx_buf_overflow, rx_buf_underflow;
  logic rx_buf_overflow, radio_irq, radio_err_irq, dma_trigger;
  logic [7:0] q;
  int n_fail, n_checks, n_cyc, n_dma, n_serr, n_txo, n_rxu, b;

  assign {radio_off_strobe, ack_strobe, ack_pending_strobe, no_ack_strobe} = strb;

  rimf_top #(.DEPTH(BUF_DEPTH)) dut (.*);
  rimf_cpu_model u_cpu (.*);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    n_cyc++;
    n_dma  += (dma_trigger === 1'b1);
    n_serr += (strobe_timing_error === 1'b1);
    n_txo  += (tx_buf_overflow === 1'b1);
    n_rxu  += (rx_buf_underflow === 1'b1);
    if (n_cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic t_reset();
    u_cpu.acc(1, 0, EXT_IRQM1_ADDR, 8'h00, q);
    chk(q, 8'h00);
    u_cpu.acc(1, 0, EXT_ERRM_ADDR, 8'h00, q);
    chk(q, 8'h00);
    u_cpu.acc(1, 0, EXT_RXCNT_ADDR, 8'h00, q);
    chk(q, 8'h00);
    u_cpu.acc(1, 0, EXT_TXCNT_ADDR, 8'h00, q);
    chk(q, 8'h00);
    u_cpu.acc(1, 0, 16'h61A0, 8'h00, q);
    chk(q, UNMAPPED_VALUE);
    chk(sfr_rdata, DATA_RESET);
    $display("reset test done");
  endtask : t_reset

  // Masks and the data port go back to reset values in mid-run
  task automatic t_rerun();
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
  endtask : t_rerun

  // One-hot pending flag reaches the request only with its own mask bit
  task automatic mask_try(input logic e, input int i);
    @(posedge clk);
    if (e) err_pending <= ERRM_W'(1 << i);
    else irq1_pending <= IRQM1_W'(1 << i);
    u_cpu.acc(1, 1, e ? EXT_ERRM_ADDR : EXT_IRQM1_ADDR, 8'(1 << i), q);
    chk({7'h00, e ? radio_err_irq : radio_irq}, 8'h01);
    u_cpu.acc(1, 1, e ? EXT_ERRM_ADDR : EXT_IRQM1_ADDR, ~8'(1 << i), q);
    chk({7'h00, e ? radio_err_irq : radio_irq}, 8'h00);
    @(posedge clk);
    {irq1_pending, err_pending} <= '0;
  endtask : mask_try

  task automatic t_masks();
    u_cpu.acc(1, 1, EXT_IRQM1_ADDR, 8'hFF, q);
    u_cpu.acc(1, 0, EXT_IRQM1_ADDR, 8'h00, q);
    chk(q, 8'h3F);
    u_cpu.acc(1, 1, EXT_ERRM_ADDR, 8'hFF, q);
    u_cpu.acc(1, 0, EXT_ERRM_ADDR, 8'h00, q);
    chk(q, 8'h7F);
    for (int i = 0; i < IRQM1_W; i++) mask_try(0, i);
    for (int i = 0; i < ERRM_W; i++) mask_try(1, i);
    // All error flags pending, all error masks cleared
    @(posedge clk) err_pending <= '1;
    u_cpu.acc(1, 1, EXT_ERRM_ADDR, 8'h00, q);
    chk({7'h00, radio_err_irq}, 8'h00);
    @(posedge clk) err_pending <= '0;
    $display("mask test done");
  endtask : t_masks

  task automatic t_strobe();
    b = n_serr;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) strb <= 4'(1 << k);
      @(posedge clk) strb <= 4'h0;
    end
    repeat (3) @(posedge clk);
    chk(8'(n_serr - b), 8'h04);
    radio_enabled <= 1'b1;
    rx_active     <= 1'b1;
    @(posedge clk) strb <= 4'hF;
    @(posedge clk) strb <= 4'h0;
    repeat (3) @(posedge clk);
    chk(8'(n_serr - b), 8'h04);
    $display("strobe test done");
  endtask : t_strobe

  task automatic t_rx();
    b = n_dma;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      rx_in_valid <= 1'b1;
      rx_in_data  <= 8'hA0 + 8'(k);
    end
    @(posedge clk) rx_in_valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk(8'(n_dma - b), 8'h01);
    u_cpu.acc(1, 0, EXT_RXCNT_ADDR, 8'h00, q);
    chk(q, 8'h03);
    for (int k = 0; k < 3; k++) begin
      u_cpu.acc(0, 0, {8'h00, SFR_DATA_ADDR}, 8'h00, q);
      chk(q, 8'hA0 + 8'(k));
    end
    chk(8'(n_dma - b), 8'h03);
    b = n_rxu;
    u_cpu.acc(0, 0, {8'h00, SFR_DATA_ADDR}, 8'h00, q);
    chk(q, 8'hA2);
    chk(8'(n_rxu - b), 8'h01);
    // Fill past full: ready drops and the extra byte is refused
    @(posedge clk) rx_in_valid <= 1'b1;
    repeat (BUF_DEPTH + 1) @(posedge clk);
    rx_in_valid <= 1'b0;
    #1 chk({6'h00, rx_in_ready, rx_buf_overflow}, 8'h01);
    u_cpu.acc(1, 0, EXT_RXCNT_ADDR, 8'h00, q);
    chk(q, 8'(BUF_DEPTH));
    @(posedge clk) flush_rx_strobe <= 1'b1;
    @(posedge clk) flush_rx_strobe <= 1'b0;
    u_cpu.acc(1, 0, EXT_RXCNT_ADDR, 8'h00, q);
    chk(q, 8'h00);
    $display("receive test done");
  endtask : t_rx

  task automatic t_tx();
    b = n_txo;
    for (int k = 0; k <= BUF_DEPTH; k++) begin
      u_cpu.acc(0, 1, {8'h00, SFR_DATA_ADDR}, 8'h10 + 8'(k), q);
    end
    chk(8'(n_txo - b), 8'h01);
    u_cpu.acc(1, 0, EXT_TXCNT_ADDR, 8'h00, q);
    chk(q, 8'(BUF_DEPTH));
    chk(tx_out_data, 8'h10);
    @(posedge clk) flush_tx_strobe <= 1'b1;
    @(posedge clk) flush_tx_strobe <= 1'b0;
    u_cpu.acc(1, 0, EXT_TXCNT_ADDR, 8'h00, q);
    chk(q, 8'h00);
    u_cpu.acc(0, 1, {8'h00, SFR_DATA_ADDR}, 8'h50, q);
    u_cpu.acc(0, 1, {8'h00, SFR_DATA_ADDR}, 8'h51, q);
    @(posedge clk) tx_out_ready <= 1'b1;
    #1 chk(tx_out_data, 8'h50);
    @(posedge clk);
    #1 chk(tx_out_data, 8'h51);
    @(posedge clk) tx_out_ready <= 1'b0;
    #1 chk({7'h00, tx_out_valid}, 8'h00);
    // Radio asks for a byte from the empty buffer
    @(posedge clk) tx_out_ready <= 1'b1;
    @(posedge clk) tx_out_ready <= 1'b0;
    #1 chk({7'h00, tx_buf_underflow}, 8'h01);
    $display("transmit test done");
  endtask : t_tx

  initial begin
    {rst_b, rx_in_valid, rx_in_data, tx_out_ready, flush_rx_strobe, flush_tx_strobe} = '0;
    {strb, radio_enabled, rx_active, irq1_pending, err_pending} = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_masks();
    t_strobe();
    t_rx();
    t_rerun();
    t_tx();
    print_verdict();
  end
endmodule : radio_irq_mask_fifo_port_test

`default_nettype wire
